// ---- verilog/slu_defs.svh ----
// Constants for the 8-bit shift and logic unit.
// Assumes nothing beyond an includer that wants these names.
`ifndef SLU_DEFS_SVH
`define SLU_DEFS_SVH
`define SLU_W 8
`define SLU_MSB 7
`define SLU_LSB 0
`define SLU_NIB 4
`define SLU_ADDR_W 8
`define SLU_OP_W 5
`define SLU_ZERO_BYTE 8'h00
`define SLU_FLAG_W 4
`define SLU_FLAG_Z 0
`define SLU_FLAG_C 1
`define SLU_FLAG_HC 2
`define SLU_FLAG_OVF 3
`endif

// ---- verilog/slu_pkg.sv ----
// Types shared by the shift and logic unit files.
// Assumes slu_defs.svh is on the include path.
`include "slu_defs.svh"
package slu_pkg;
  typedef enum logic [`SLU_OP_W-1:0] {
    SLU_OP_NONE = 5'h00,
    SLU_OP_SHR_W = 5'h01,
    SLU_OP_ROR_W = 5'h02,
    SLU_OP_SHR_M = 5'h03,
    SLU_OP_ROR_M = 5'h04,
    SLU_OP_SHL_W = 5'h05,
    SLU_OP_ROL_W = 5'h06,
    SLU_OP_SHL_M = 5'h07,
    SLU_OP_ROL_M = 5'h08,
    SLU_OP_SWAP_W = 5'h09,
    SLU_OP_AND_WI = 5'h0A,
    SLU_OP_AND_WM = 5'h0B,
    SLU_OP_AND_MW = 5'h0C,
    SLU_OP_OR_WI = 5'h0D,
    SLU_OP_OR_WM = 5'h0E,
    SLU_OP_OR_MW = 5'h0F,
    SLU_OP_XOR_WI = 5'h10,
    SLU_OP_XOR_WM = 5'h11,
    SLU_OP_XOR_MW = 5'h12,
    SLU_OP_XOR_IO = 5'h13
  } slu_op_t;

  typedef enum logic [1:0] {
    SLU_LG_AND = 2'h0,
    SLU_LG_OR = 2'h1,
    SLU_LG_XOR = 2'h2
  } slu_logic_t;

  typedef enum logic [1:0] {
    SLU_DST_NONE = 2'h0,
    SLU_DST_WORK = 2'h1,
    SLU_DST_MEM = 2'h2,
    SLU_DST_IO = 2'h3
  } slu_dst_t;

  function automatic logic slu_is_zero(input logic [`SLU_W-1:0] value);
    return value == `SLU_ZERO_BYTE;
  endfunction
endpackage

// ---- verilog/slu_shifter.sv ----
// One-place shift, rotate through carry, and nibble swap of a byte.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`include "slu_defs.svh"
module slu_shifter (
  input wire logic [`SLU_W-1:0] operand,
  input wire logic carry_in,
  input wire logic left,
  input wire logic through_carry,
  input wire logic swap_nibbles,
  output logic [`SLU_W-1:0] result,
  output logic carry_out
);
  import slu_pkg::*;

  always_comb begin
    if (swap_nibbles) begin
      result = {operand[`SLU_NIB-1:`SLU_LSB], operand[`SLU_MSB:`SLU_NIB]}; // see RQ10
      carry_out = carry_in;
    end else if (left) begin
      // Lowest bit takes old carry or zero; old top bit leaves to carry
      result = {operand[`SLU_MSB-1:`SLU_LSB], through_carry & carry_in}; // see RQ5 see RQ6
      carry_out = operand[`SLU_MSB];
    end else begin
      result = {through_carry & carry_in, operand[`SLU_MSB:`SLU_LSB+1]}; // see RQ1 see RQ2
      carry_out = operand[`SLU_LSB];
    end
  end
endmodule

// ---- verilog/slu_logic.sv ----
// Bitwise AND, OR and XOR of two bytes with a zero indication.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`include "slu_defs.svh"
module slu_logic (
  input wire logic [`SLU_W-1:0] a,
  input wire logic [`SLU_W-1:0] b,
  input wire slu_pkg::slu_logic_t fn,
  output logic [`SLU_W-1:0] result,
  output logic zero
);
  import slu_pkg::*;

  always_comb begin
    case (fn)
      SLU_LG_AND: result = a & b; // see RQ11
      SLU_LG_OR: result = a | b; // see RQ12
      SLU_LG_XOR: result = a ^ b; // see RQ13
      default: result = a;
    endcase
    zero = slu_is_zero(result); // see RQ16
  end
endmodule

// ---- verilog/slu_top.sv ----
// Shift, rotate, nibble swap and bitwise logic unit of an 8-bit core.
// Assumes the core presents memory and IO read data with the request
// and performs the writes that this unit requests one cycle later.
//
// Contract
// RQ1: Right shift work register, zero in, carry out
// RQ2: Right rotate work register through carry
// RQ3: Right shift memory byte, write back, carry
// RQ4: Right rotate memory byte through carry, write back
// RQ5: Left shift work register, zero in, carry out
// RQ6: Left rotate work register through carry
// RQ7: Left shift memory byte, write back, carry
// RQ8: Left rotate memory byte through carry, write back
// RQ9: Shifts and rotates change only carry
// RQ10: Nibble swap of work register, no flags
// RQ11: AND with immediate or memory byte
// RQ12: OR with immediate or memory byte
// RQ13: XOR with immediate or memory byte
// RQ14: Logic ops update zero flag only
// RQ15: XOR into IO register, no flags
// RQ16: Zero flag set when result all zero
`timescale 1ns/1ns
`include "slu_defs.svh"
module slu_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire slu_pkg::slu_op_t op_code,
  input wire logic [`SLU_W-1:0] op_imm,
  input wire logic [`SLU_ADDR_W-1:0] mem_addr,
  input wire logic [`SLU_W-1:0] mem_rdata,
  input wire logic [`SLU_ADDR_W-1:0] io_addr,
  input wire logic [`SLU_W-1:0] io_rdata,
  input wire logic work_load,
  input wire logic [`SLU_W-1:0] work_in,
  input wire logic flags_load,
  input wire logic [`SLU_FLAG_W-1:0] flags_in,
  output logic [`SLU_W-1:0] work_register,
  output logic zero_flag,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic overflow_flag,
  output logic mem_wr_en,
  output logic [`SLU_ADDR_W-1:0] mem_waddr,
  output logic [`SLU_W-1:0] mem_wdata,
  output logic io_wr_en,
  output logic [`SLU_ADDR_W-1:0] io_waddr,
  output logic [`SLU_W-1:0] io_wdata,
  output logic op_done
);
  import slu_pkg::*;

  logic take;
  logic is_shift;
  logic is_logic;
  logic sh_left;
  logic sh_through;
  logic sh_swap;
  logic [`SLU_W-1:0] sh_operand;
  logic [`SLU_W-1:0] sh_result;
  logic sh_carry;
  slu_logic_t lg_fn;
  logic [`SLU_W-1:0] lg_b;
  logic [`SLU_W-1:0] lg_result;
  logic lg_zero;
  slu_dst_t dst;
  logic [`SLU_W-1:0] next_result;

  assign take = clk_en & op_valid;

  // Operation decode: operand source, shift form, logic function, target
  always_comb begin
    is_shift = 1'h0;
    is_logic = 1'h0;
    sh_left = 1'h0;
    sh_through = 1'h0;
    sh_swap = 1'h0;
    sh_operand = work_register;
    lg_fn = SLU_LG_AND;
    lg_b = op_imm;
    dst = SLU_DST_NONE;
    case (op_code)
      SLU_OP_SHR_W: begin
        is_shift = 1'h1;
        dst = SLU_DST_WORK; // see RQ1
      end
      SLU_OP_ROR_W: begin
        is_shift = 1'h1;
        sh_through = 1'h1;
        dst = SLU_DST_WORK; // see RQ2
      end
      SLU_OP_SHR_M: begin
        is_shift = 1'h1;
        sh_operand = mem_rdata;
        dst = SLU_DST_MEM; // see RQ3
      end
      SLU_OP_ROR_M: begin
        is_shift = 1'h1;
        sh_through = 1'h1;
        sh_operand = mem_rdata;
        dst = SLU_DST_MEM; // see RQ4
      end
      SLU_OP_SHL_W: begin
        is_shift = 1'h1;
        sh_left = 1'h1;
        dst = SLU_DST_WORK; // see RQ5
      end
      SLU_OP_ROL_W: begin
        is_shift = 1'h1;
        sh_left = 1'h1;
        sh_through = 1'h1;
        dst = SLU_DST_WORK; // see RQ6
      end
      SLU_OP_SHL_M: begin
        is_shift = 1'h1;
        sh_left = 1'h1;
        sh_operand = mem_rdata;
        dst = SLU_DST_MEM; // see RQ7
      end
      SLU_OP_ROL_M: begin
        is_shift = 1'h1;
        sh_left = 1'h1;
        sh_through = 1'h1;
        sh_operand = mem_rdata;
        dst = SLU_DST_MEM; // see RQ8
      end
      SLU_OP_SWAP_W: begin
        sh_swap = 1'h1;
        dst = SLU_DST_WORK; // see RQ10
      end
      SLU_OP_AND_WI, SLU_OP_OR_WI, SLU_OP_XOR_WI: begin
        is_logic = 1'h1;
        dst = SLU_DST_WORK;
      end
      SLU_OP_AND_WM, SLU_OP_OR_WM, SLU_OP_XOR_WM: begin
        is_logic = 1'h1;
        lg_b = mem_rdata;
        dst = SLU_DST_WORK;
      end
      SLU_OP_AND_MW, SLU_OP_OR_MW, SLU_OP_XOR_MW: begin
        is_logic = 1'h1;
        lg_b = mem_rdata;
        dst = SLU_DST_MEM;
      end
      SLU_OP_XOR_IO: begin
        lg_b = io_rdata;
        dst = SLU_DST_IO; // see RQ15
      end
      default: begin
        dst = SLU_DST_NONE;
      end
    endcase
    case (op_code)
      SLU_OP_OR_WI, SLU_OP_OR_WM, SLU_OP_OR_MW: lg_fn = SLU_LG_OR;
      SLU_OP_XOR_WI, SLU_OP_XOR_WM, SLU_OP_XOR_MW, SLU_OP_XOR_IO: lg_fn = SLU_LG_XOR;
      default: lg_fn = SLU_LG_AND;
    endcase
  end

  slu_shifter u_shifter (
    .operand(sh_operand),
    .carry_in(carry_flag),
    .left(sh_left),
    .through_carry(sh_through),
    .swap_nibbles(sh_swap),
    .result(sh_result),
    .carry_out(sh_carry)
  );

  slu_logic u_logic (
    .a(work_register),
    .b(lg_b),
    .fn(lg_fn),
    .result(lg_result),
    .zero(lg_zero)
  );

  assign next_result = (is_shift | sh_swap) ? sh_result : lg_result;

  // Work register: operation result wins over a core load in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      work_register <= `SLU_ZERO_BYTE;
    end else if (clk_en) begin
      if (op_valid && dst == SLU_DST_WORK) begin
        work_register <= next_result;
      end else if (work_load && !op_valid) begin
        work_register <= work_in;
      end
    end
  end

  // Flags: shifts touch carry, memory/immediate logic ops touch zero only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      zero_flag <= 1'h0;
      carry_flag <= 1'h0;
      half_carry_flag <= 1'h0;
      overflow_flag <= 1'h0;
    end else if (clk_en) begin
      if (op_valid) begin
        if (is_shift) begin
          carry_flag <= sh_carry; // see RQ9
        end
        if (is_logic) begin
          zero_flag <= lg_zero; // see RQ14 see RQ16
        end
      end else if (flags_load) begin
        zero_flag <= flags_in[`SLU_FLAG_Z];
        carry_flag <= flags_in[`SLU_FLAG_C];
        half_carry_flag <= flags_in[`SLU_FLAG_HC];
        overflow_flag <= flags_in[`SLU_FLAG_OVF];
      end
    end
  end

  // Memory write-back to the location that supplied the operand
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_wr_en <= 1'h0;
      mem_waddr <= `SLU_ZERO_BYTE;
      mem_wdata <= `SLU_ZERO_BYTE;
    end else if (clk_en) begin
      mem_wr_en <= op_valid && dst == SLU_DST_MEM; // see RQ3 see RQ7
      if (op_valid && dst == SLU_DST_MEM) begin
        mem_waddr <= mem_addr;
        mem_wdata <= next_result;
      end
    end
  end

  // IO register write-back
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      io_wr_en <= 1'h0;
      io_waddr <= `SLU_ZERO_BYTE;
      io_wdata <= `SLU_ZERO_BYTE;
    end else if (clk_en) begin
      io_wr_en <= op_valid && dst == SLU_DST_IO; // see RQ15
      if (op_valid && dst == SLU_DST_IO) begin
        io_waddr <= io_addr;
        io_wdata <= lg_result;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op_done <= 1'h0;
    end else if (clk_en) begin
      op_done <= op_valid && dst != SLU_DST_NONE;
    end
  end

  // History of the inputs and state of the last enabled cycle, taken or not, read only by the checks below
  logic hist_take;
  slu_op_t hist_op;
  logic [`SLU_W-1:0] hist_work;
  logic [`SLU_W-1:0] hist_mem;
  logic [`SLU_W-1:0] hist_imm;
  logic [`SLU_W-1:0] hist_io;
  logic [`SLU_FLAG_W-1:0] hist_flags;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hist_take <= 1'h0;
      hist_op <= SLU_OP_NONE;
      hist_work <= `SLU_ZERO_BYTE;
      hist_mem <= `SLU_ZERO_BYTE;
      hist_imm <= `SLU_ZERO_BYTE;
      hist_io <= `SLU_ZERO_BYTE;
      hist_flags <= 4'h0;
    end else if (clk_en) begin
      hist_take <= take;
      hist_op <= op_code;
      hist_work <= work_register;
      hist_mem <= mem_rdata;
      hist_imm <= op_imm;
      hist_io <= io_rdata;
      hist_flags <= {overflow_flag, half_carry_flag, carry_flag, zero_flag};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  shr_work_a: assert property (hist_take && hist_op == SLU_OP_SHR_W |-> // see RQ1
    work_register == {1'h0, hist_work[`SLU_MSB:`SLU_LSB+1]} && carry_flag == hist_work[`SLU_LSB])
    else $error("right shift of work register wrong");
  ror_work_a: assert property (hist_take && hist_op == SLU_OP_ROR_W |-> // see RQ2
    work_register == {hist_flags[`SLU_FLAG_C], hist_work[`SLU_MSB:`SLU_LSB+1]}
    && carry_flag == hist_work[`SLU_LSB])
    else $error("right rotate of work register wrong");
  shr_mem_a: assert property (take && op_code == SLU_OP_SHR_M |=> // see RQ3
    mem_wr_en && mem_waddr == $past(mem_addr) && mem_wdata == {1'h0, hist_mem[`SLU_MSB:1]}
    && carry_flag == hist_mem[`SLU_LSB])
    else $error("right shift of memory byte wrong");
  ror_mem_a: assert property (hist_take && hist_op == SLU_OP_ROR_M |-> // see RQ4
    mem_wdata == {hist_flags[`SLU_FLAG_C], hist_mem[`SLU_MSB:1]} && carry_flag == hist_mem[0])
    else $error("right rotate of memory byte wrong");
  shl_work_a: assert property (hist_take && hist_op == SLU_OP_SHL_W |-> // see RQ5
    work_register == {hist_work[`SLU_MSB-1:`SLU_LSB], 1'h0} && carry_flag == hist_work[`SLU_MSB])
    else $error("left shift of work register wrong");
  rol_work_a: assert property (hist_take && hist_op == SLU_OP_ROL_W |-> // see RQ6
    work_register == {hist_work[`SLU_MSB-1:`SLU_LSB], hist_flags[`SLU_FLAG_C]}
    && carry_flag == hist_work[`SLU_MSB])
    else $error("left rotate of work register wrong");
  shl_mem_a: assert property (hist_take && hist_op == SLU_OP_SHL_M |-> // see RQ7
    mem_wr_en && mem_wdata == {hist_mem[`SLU_MSB-1:`SLU_LSB], 1'h0}
    && carry_flag == hist_mem[`SLU_MSB])
    else $error("left shift of memory byte wrong");
  rol_mem_a: assert property (hist_take && hist_op == SLU_OP_ROL_M |-> // see RQ8
    mem_wdata == {hist_mem[`SLU_MSB-1:`SLU_LSB], hist_flags[`SLU_FLAG_C]}
    && carry_flag == hist_mem[`SLU_MSB])
    else $error("left rotate of memory byte wrong");
  shift_flags_a: assert property (hist_take // see RQ9
    && hist_op inside {[SLU_OP_SHR_W:SLU_OP_ROL_M]} |->
    zero_flag == hist_flags[`SLU_FLAG_Z] && half_carry_flag == hist_flags[`SLU_FLAG_HC]
    && overflow_flag == hist_flags[`SLU_FLAG_OVF])
    else $error("shift altered a flag other than carry");
  swap_work_a: assert property (hist_take && hist_op == SLU_OP_SWAP_W |-> // see RQ10
    work_register == {hist_work[`SLU_NIB-1:0], hist_work[`SLU_MSB:`SLU_NIB]}
    && {overflow_flag, half_carry_flag, carry_flag, zero_flag} == hist_flags)
    else $error("nibble swap wrong");
  and_imm_a: assert property (hist_take && hist_op == SLU_OP_AND_WI |-> // see RQ11
    work_register == (hist_work & hist_imm))
    else $error("and with immediate wrong");
  or_mem_a: assert property (hist_take && hist_op == SLU_OP_OR_MW |-> // see RQ12
    mem_wr_en && mem_wdata == (hist_work | hist_mem) && work_register == hist_work)
    else $error("or into memory wrong");
  xor_mem_a: assert property (hist_take && hist_op == SLU_OP_XOR_WM |-> // see RQ13
    work_register == (hist_work ^ hist_mem))
    else $error("xor with memory wrong");
  logic_flags_a: assert property (hist_take // see RQ14
    && hist_op inside {[SLU_OP_AND_WI:SLU_OP_XOR_MW]} |->
    {overflow_flag, half_carry_flag, carry_flag} == hist_flags[`SLU_FLAG_OVF:`SLU_FLAG_C])
    else $error("logic op altered carry or upper flags");
  xor_io_a: assert property (take && op_code == SLU_OP_XOR_IO |=> // see RQ15
    io_wr_en && io_wdata == (hist_work ^ hist_io) && !mem_wr_en
    && {overflow_flag, half_carry_flag, carry_flag, zero_flag} == hist_flags)
    else $error("xor into io register wrong");
  // Memory-destination forms judge zero on the written byte, not the work register
  zero_set_a: assert property (hist_take // see RQ16
    && hist_op inside {[SLU_OP_AND_WI:SLU_OP_XOR_MW]} |->
    zero_flag == (hist_op inside {SLU_OP_AND_MW, SLU_OP_OR_MW, SLU_OP_XOR_MW}
    ? mem_wdata == `SLU_ZERO_BYTE : work_register == `SLU_ZERO_BYTE))
    else $error("zero flag disagrees with result");
endmodule

// ---- test/slu_mem_model.sv ----
// Data memory and IO register model on the far side of the shift and logic unit.
// Assumes the unit's write strobes are sampled on the rising clock edge.
`timescale 1ns/1ns
`include "slu_defs.svh"
module slu_mem_model (
  input wire logic ref_clk,
  input wire logic [`SLU_ADDR_W-1:0] mem_addr,
  output logic [`SLU_W-1:0] mem_rdata,
  input wire logic mem_wr_en,
  input wire logic [`SLU_ADDR_W-1:0] mem_waddr,
  input wire logic [`SLU_W-1:0] mem_wdata,
  input wire logic [`SLU_ADDR_W-1:0] io_addr,
  output logic [`SLU_W-1:0] io_rdata,
  input wire logic io_wr_en,
  input wire logic [`SLU_ADDR_W-1:0] io_waddr,
  input wire logic [`SLU_W-1:0] io_wdata
);
  logic [`SLU_W-1:0] mem [256];
  logic [`SLU_W-1:0] io [256];
  assign mem_rdata = mem[mem_addr];
  assign io_rdata = io[io_addr];
  // Plain always so the bench may preload cells directly
  always @(posedge ref_clk) begin
    if (mem_wr_en) begin
      mem[mem_waddr] <= mem_wdata;
    end
    if (io_wr_en) begin
      io[io_waddr] <= io_wdata;
    end
  end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the shift and logic unit.
// Assumes slu_pkg and slu_mem_model are compiled first.
`timescale 1ns/1ns
`include "slu_defs.svh"
module testbench;
  import slu_pkg::*;
  logic ref_clk, reset, clk_en, op_valid, work_load, flags_load;
  slu_op_t op_code;
  logic [7:0] op_imm, mem_addr, io_addr, work_in, mem_rdata, io_rdata, work_register;
  logic [7:0] mem_waddr, mem_wdata, io_waddr, io_wdata;
  logic [3:0] flags_in, flags;
  logic zero_flag, carry_flag, half_carry_flag, overflow_flag, mem_wr_en, io_wr_en, op_done;
  int fails;
  int check_count;
  assign flags = {overflow_flag, half_carry_flag, carry_flag, zero_flag};

  slu_top i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .io_addr(io_addr), .io_rdata(io_rdata), .work_load(work_load), .work_in(work_in),
    .flags_load(flags_load), .flags_in(flags_in), .work_register(work_register),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .overflow_flag(overflow_flag), .mem_wr_en(mem_wr_en), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .io_wr_en(io_wr_en), .io_waddr(io_waddr), .io_wdata(io_wdata),
    .op_done(op_done));

  slu_mem_model i_mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wr_en(mem_wr_en), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .io_addr(io_addr), .io_rdata(io_rdata), .io_wr_en(io_wr_en), .io_waddr(io_waddr),
    .io_wdata(io_wdata));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic preset(input logic [7:0] w, input logic [3:0] f);
    @(negedge ref_clk);
    work_load = 1'b1;
    work_in = w;
    flags_load = 1'b1;
    flags_in = f;
    @(negedge ref_clk);
    work_load = 1'b0;
    flags_load = 1'b0;
  endtask

  // One operation from preset state, judged against a reference worked out here
  task automatic run(input slu_op_t code, input logic [7:0] w, input logic [3:0] f,
                     input logic [7:0] m, input logic [7:0] imm, input logic [7:0] iov);
    logic [7:0] r;
    logic [7:0] src;
    logic [3:0] ef;
    logic dm;
    logic di;
    i_mem.mem[8'h40] = m;
    i_mem.io[8'h1C] = iov;
    preset(w, f);
    op_valid = 1'b1;
    op_code = code;
    op_imm = imm;
    mem_addr = 8'h40;
    io_addr = 8'h1C;
    @(negedge ref_clk);
    op_valid = 1'b0;
    dm = code inside {SLU_OP_SHR_M, SLU_OP_ROR_M, SLU_OP_SHL_M, SLU_OP_ROL_M,
                      SLU_OP_AND_MW, SLU_OP_OR_MW, SLU_OP_XOR_MW};
    di = (code == SLU_OP_XOR_IO);
    src = dm ? m : w;
    ef = f;
    case (code)
      SLU_OP_SHR_W, SLU_OP_SHR_M: r = {1'b0, src[7:1]};
      SLU_OP_ROR_W, SLU_OP_ROR_M: r = {f[1], src[7:1]};
      SLU_OP_SHL_W, SLU_OP_SHL_M: r = {src[6:0], 1'b0};
      SLU_OP_ROL_W, SLU_OP_ROL_M: r = {src[6:0], f[1]};
      SLU_OP_SWAP_W: r = {w[3:0], w[7:4]};
      SLU_OP_AND_WI: r = w & imm;
      SLU_OP_AND_WM, SLU_OP_AND_MW: r = w & m;
      SLU_OP_OR_WI: r = w | imm;
      SLU_OP_OR_WM, SLU_OP_OR_MW: r = w | m;
      SLU_OP_XOR_WI: r = w ^ imm;
      SLU_OP_XOR_WM, SLU_OP_XOR_MW: r = w ^ m;
      default: r = w ^ iov;
    endcase
    if (code >= SLU_OP_SHR_W && code <= SLU_OP_ROR_M) ef[1] = src[0];
    if (code >= SLU_OP_SHL_W && code <= SLU_OP_ROL_M) ef[1] = src[7];
    if (code >= SLU_OP_AND_WI && code <= SLU_OP_XOR_MW) ef[0] = (r == 8'h00);
    cmp(work_register, (dm || di) ? w : r, "work result");
    cmp({4'h0, flags}, {4'h0, ef}, "flags");
    cmp({7'h0, op_done}, 8'h01, "done pulse");
    cmp({7'h0, mem_wr_en}, {7'h0, dm}, "mem strobe");
    cmp({7'h0, io_wr_en}, {7'h0, di}, "io strobe");
    if (dm) cmp(mem_wdata, r, "mem data");
    if (dm) cmp(mem_waddr, 8'h40, "mem addr");
    if (di) cmp(io_wdata, r, "io data");
    if (di) cmp(io_waddr, 8'h1C, "io addr");
    @(negedge ref_clk);
    cmp({6'h0, mem_wr_en, io_wr_en}, 8'h00, "strobes end");
    if (dm) cmp(i_mem.mem[8'h40], r, "mem cell");
    if (di) cmp(i_mem.io[8'h1C], r, "io cell");
  endtask

  task automatic test_shifts();
    slu_op_t ops[8] = '{SLU_OP_SHR_W, SLU_OP_ROR_W, SLU_OP_SHL_W, SLU_OP_ROL_W,
                        SLU_OP_SHR_M, SLU_OP_ROR_M, SLU_OP_SHL_M, SLU_OP_ROL_M};
    foreach (ops[i]) begin
      run(ops[i], 8'h81, 4'hE, 8'h7E, 8'h00, 8'h00);
      run(ops[i], 8'h7E, 4'h1, 8'h81, 8'h00, 8'h00);
    end
    $display("done shifts");
  endtask

  task automatic test_swap();
    run(SLU_OP_SWAP_W, 8'hA5, 4'hB, 8'h00, 8'h00, 8'h00);
    run(SLU_OP_SWAP_W, 8'h0F, 4'h4, 8'h00, 8'h00, 8'h00);
    $display("done swap");
  endtask

  task automatic test_logic();
    slu_op_t ops[9] = '{SLU_OP_AND_WI, SLU_OP_AND_WM, SLU_OP_AND_MW, SLU_OP_OR_WI,
                        SLU_OP_OR_WM, SLU_OP_OR_MW, SLU_OP_XOR_WI, SLU_OP_XOR_WM, SLU_OP_XOR_MW};
    foreach (ops[i]) begin
      run(ops[i], 8'hF0, 4'hE, 8'h0F, 8'h0F, 8'h00);
      run(ops[i], 8'h3C, 4'hF, 8'h3C, 8'h3C, 8'h00);
    end
    $display("done logic");
  endtask

  task automatic test_xor_io();
    run(SLU_OP_XOR_IO, 8'h5A, 4'h0, 8'h00, 8'h00, 8'h5A);
    run(SLU_OP_XOR_IO, 8'hFF, 4'hF, 8'h00, 8'h00, 8'h0F);
    $display("done io xor");
  endtask

  task automatic test_seq();
    preset(8'hC1, 4'h0);
    op_valid = 1'b1;
    op_code = SLU_OP_SHL_W;
    work_load = 1'b1;
    work_in = 8'hFF;
    @(negedge ref_clk);
    cmp(work_register, 8'h82, "first of pair");
    op_code = SLU_OP_ROL_W;
    work_load = 1'b0;
    @(negedge ref_clk);
    cmp(work_register, 8'h05, "second of pair");
    cmp({7'h0, carry_flag}, 8'h01, "pair carry");
    op_code = SLU_OP_NONE;
    @(negedge ref_clk);
    cmp({7'h0, op_done}, 8'h00, "none done");
    clk_en = 1'b0;
    op_code = SLU_OP_SHR_W;
    @(negedge ref_clk);
    cmp(work_register, 8'h05, "frozen");
    op_valid = 1'b0;
    clk_en = 1'b1;
    $display("done sequence");
  endtask

  initial begin
    #400000;
    fails++;
    complete_run();
  end

  initial begin
    fails = 0;
    check_count = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    op_valid = 1'b0;
    op_code = SLU_OP_NONE;
    op_imm = 8'h00;
    mem_addr = 8'h00;
    io_addr = 8'h00;
    work_load = 1'b0;
    work_in = 8'h00;
    flags_load = 1'b0;
    flags_in = 4'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    cmp(work_register, 8'h00, "reset work");
    cmp({4'h0, flags}, 8'h00, "reset flags");
    test_shifts();
    test_swap();
    test_logic();
    test_xor_io();
    test_seq();
    complete_run();
  end
endmodule
